/* File: logic/sequencer_map.vh */
// constants for the setpoint program sequencer
`ifndef SEQUENCER_MAP_VH
`define SEQUENCER_MAP_VH
`define CLK_HZ 50000000
`define SEC_CYCLES (`CLK_HZ)
`define TICK_W 26
`define REPEAT_MAX 14'h270f
`define REPEAT_DEF 14'h0000
`define LINK_END 4'h8
`define LINK_DEF 4'h8
`define SEG_MAX 5'h1f
`define TS_SEG_DEF 5'h00
`define SEGS_DEF 6'h08
`define SEGS_MIN 6'h01
`define SEGS_MAX 6'h20
`define DLY_MM_MAX 7'h63
`define DLY_LO_MAX 6'h3b
`define DLY_DEF 13'h0000
`define UNIT_HM 1'b0
`define UNIT_MS 1'b1
`define SRC_PROG 2'h0
`define SRC_FIXED 2'h1
`define SRC_REMOTE 2'h2
`define PROT_OPEN_MAX 3'h1
`define FIXED_DEF 16'h0000
`define SP_W 16
`define TIME_W 13
`define UNITS_PER_HI 13'h03c
`endif

/* File: logic/program_store.v */
// small memory holding per-segment setpoints and times for eight programs
`timescale 1ns/10ps
module program_store (
  // clock
  input wire clk,
  input wire ce,
  // write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [28:0] wr_data,
  // read port, registered
  input wire [7:0] rd_addr,
  output reg [28:0] rd_data
);
  reg [28:0] mem [0:255];
  always @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // program_store

/* File: logic/setpoint_program_sequencer.v */
// setpoint program sequencer: repeat, link, time signals, setpoint source
//
// How it works
// - a program runs repeat count plus one times; count 0..9999, default 0
// - after a program ends, run the linked program or END; default END
// - each time signal names one segment 0..31, default 0
// - two time signals per program, each one ON delay and one OFF delay
// - time-signal settings act only when outputs are assigned to them
// - delays accept 0.00..99.59, default 0.00
// - delay time base follows program time unit, default hours-minutes
// - program mode uses the running program's setpoint
// - program mode refused while reset operation is fixed-setpoint
// - fixed mode controls to stored fixed setpoint and lights its lamp
// - remote mode takes external setpoint and lights its lamp
// - mode selector holds program, fixed or remote, default program
// - fixed setpoint clamped to setpoint limits, default 0.0
// - mode and fixed setpoint change only at protection 0 or 1
// - programs are numbered 0..7
// - a program uses 1..32 segments, default 8
`timescale 1ns/10ps
`include "sequencer_map.vh"
module setpoint_program_sequencer (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // run control
  input wire run,
  input wire [2:0] start_program,
  input wire time_unit_ms,
  // program settings write
  input wire cfg_wr,
  input wire [2:0] cfg_program,
  input wire [13:0] program_repeat_count,
  input wire [3:0] link_program,
  input wire [5:0] segments_used,
  input wire [4:0] ts1_segment,
  input wire [4:0] ts2_segment,
  input wire [12:0] ts1_on_delay,
  input wire [12:0] ts1_off_delay,
  input wire [12:0] ts2_on_delay,
  input wire [12:0] ts2_off_delay,
  // segment table write: setpoint and time
  input wire seg_wr,
  input wire [7:0] seg_addr,
  input wire [15:0] seg_setpoint,
  input wire [12:0] seg_time,
  // time signal output assignment
  input wire ts1_assigned,
  input wire ts2_assigned,
  // setpoint source
  input wire mode_wr,
  input wire [1:0] setpoint_source_select,
  input wire fixed_wr,
  input wire [15:0] stored_constant_setpoint,
  input wire [15:0] sp_lower_limit,
  input wire [15:0] sp_upper_limit,
  input wire reset_op_fixed,
  input wire [2:0] protect_level,
  input wire [15:0] remote_setpoint,
  // outputs
  output reg [15:0] control_setpoint,
  output reg fixed_lamp,
  output reg remote_lamp,
  output reg ts1_out,
  output reg ts2_out,
  output reg running,
  output reg finished,
  output reg [2:0] current_program,
  output reg [4:0] current_segment,
  output reg [1:0] source_mode,
  output reg mode_refused
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam ST_IDLE = 5'b00001;
  localparam ST_FETCH = 5'b00010;
  localparam ST_LOAD = 5'b00100;
  localparam ST_RUN = 5'b01000;
  localparam ST_END = 5'b10000;
  // delay in mm.ss (or hh.mm) bcd-free form: high part*60 + low part
  function [12:0] to_units;
    input [12:0] d;
    reg [6:0] hi;
    reg [5:0] lo;
    begin
      hi = d[12:6];
      lo = d[5:0];
      if (hi > `DLY_MM_MAX) hi = `DLY_MM_MAX;
      if (lo > `DLY_LO_MAX) lo = `DLY_LO_MAX;
      to_units = ({6'h00, hi} * `UNITS_PER_HI) + {7'h00, lo};
    end
  endfunction
  function [15:0] clamp_sp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if ($signed(v) < $signed(lo)) clamp_sp = lo;
      else if ($signed(v) > $signed(hi)) clamp_sp = hi;
      else clamp_sp = v;
    end
  endfunction
  // ----------------------------------------------------------------
  // per-program settings
  // ----------------------------------------------------------------
  reg [13:0] rep_reg [0:7];
  reg [3:0] link_reg [0:7];
  reg [5:0] segs_reg [0:7];
  reg [4:0] tsseg_reg [0:15];
  reg [12:0] on_reg [0:15];
  reg [12:0] off_reg [0:15];

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : cfg
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          rep_reg[g] <= `REPEAT_DEF;
          link_reg[g] <= `LINK_DEF;
          segs_reg[g] <= `SEGS_DEF;
          tsseg_reg[2*g] <= `TS_SEG_DEF;
          tsseg_reg[2*g+1] <= `TS_SEG_DEF;
          on_reg[2*g] <= `DLY_DEF;
          on_reg[2*g+1] <= `DLY_DEF;
          off_reg[2*g] <= `DLY_DEF;
          off_reg[2*g+1] <= `DLY_DEF;
        end else if (ce && cfg_wr && cfg_program == g) begin
          rep_reg[g] <= (program_repeat_count > `REPEAT_MAX) ? `REPEAT_MAX
                        : program_repeat_count;
          link_reg[g] <= (link_program > `LINK_END) ? `LINK_END : link_program;
          segs_reg[g] <= (segments_used < `SEGS_MIN) ? `SEGS_MIN
                         : (segments_used > `SEGS_MAX) ? `SEGS_MAX : segments_used;
          tsseg_reg[2*g] <= ts1_segment;
          tsseg_reg[2*g+1] <= ts2_segment;
          on_reg[2*g] <= ts1_on_delay;
          on_reg[2*g+1] <= ts2_on_delay;
          off_reg[2*g] <= ts1_off_delay;
          off_reg[2*g+1] <= ts2_off_delay;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // segment memory
  // ----------------------------------------------------------------
  wire [28:0] seg_rd;
  wire [7:0] rd_addr;
  assign rd_addr = {current_program, current_segment};
  program_store store (
    .clk(clk),
    .ce(ce),
    .wr_en(seg_wr),
    .wr_addr(seg_addr),
    .wr_data({seg_setpoint, seg_time}),
    .rd_addr(rd_addr),
    .rd_data(seg_rd)
  );
  // ----------------------------------------------------------------
  // time base: one tick per second or per minute of program time
  // ----------------------------------------------------------------
  reg [`TICK_W-1:0] sec_reg;
  reg [5:0] min_reg;
  reg unit_tick;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_reg <= {`TICK_W{1'b0}};
      min_reg <= 6'h00;
      unit_tick <= 1'b0;
    end else if (ce) begin
      unit_tick <= 1'b0;
      if (!running) begin
        sec_reg <= {`TICK_W{1'b0}};
        min_reg <= 6'h00;
      end else if (sec_reg == `SEC_CYCLES - 1) begin
        sec_reg <= {`TICK_W{1'b0}};
        // minutes-seconds: unit is a second; hours-minutes: a minute
        if (time_unit_ms == `UNIT_MS || min_reg == `DLY_LO_MAX) begin
          min_reg <= 6'h00;
          unit_tick <= 1'b1;
        end else begin
          min_reg <= min_reg + 6'h01;
        end
      end else begin
        sec_reg <= sec_reg + 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  reg [4:0] state_reg;
  reg [13:0] pass_reg;
  reg [12:0] seg_left_reg;
  reg [12:0] ts_cnt_reg;
  reg [15:0] prog_sp_reg;
  wire [3:0] lnk;
  wire last_seg;
  assign lnk = link_reg[current_program];
  assign last_seg = ({1'b0, current_segment} + 6'h01) >= segs_reg[current_program];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      pass_reg <= 14'h0000;
      seg_left_reg <= 13'h0000;
      ts_cnt_reg <= 13'h0000;
      prog_sp_reg <= 16'h0000;
      current_program <= 3'h0;
      current_segment <= 5'h00;
      running <= 1'b0;
      finished <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (run) begin
            current_program <= start_program;
            current_segment <= 5'h00;
            pass_reg <= 14'h0000;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // the store registers the new address here; its data stand next cycle
          state_reg <= run ? ST_LOAD : ST_IDLE;
        end
        ST_LOAD: begin
          // read data for the current address stand now
          if (run) begin
            state_reg <= ST_RUN;
            running <= 1'b1;
            seg_left_reg <= to_units(seg_rd[12:0]);
            ts_cnt_reg <= 13'h0000;
            prog_sp_reg <= seg_rd[28:13];
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RUN: begin
          if (!run) begin
            running <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (seg_left_reg == 13'h0000) begin
            running <= 1'b0;
            state_reg <= ST_FETCH;
            if (!last_seg) begin
              current_segment <= current_segment + 5'h01;
            end else if (pass_reg < rep_reg[current_program]) begin
              pass_reg <= pass_reg + 14'h0001;
              current_segment <= 5'h00;
            end else if (lnk == `LINK_END) begin
              state_reg <= ST_END;
              finished <= 1'b1;
            end else begin
              current_program <= lnk[2:0];
              current_segment <= 5'h00;
              pass_reg <= 14'h0000;
            end
          end else if (unit_tick) begin
            seg_left_reg <= seg_left_reg - 13'h0001;
            ts_cnt_reg <= ts_cnt_reg + 13'h0001;
          end
        end
        ST_END: begin
          // holds at the last segment until run drops
          if (!run) begin
            state_reg <= ST_IDLE;
            finished <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // time signals
  // ----------------------------------------------------------------
  wire [1:0] ts_assigned;
  wire [1:0] ts_next;
  assign ts_assigned = {ts2_assigned, ts1_assigned};
  generate
    for (g = 0; g < 2; g = g + 1) begin : tsig
      wire [3:0] idx;
      wire [12:0] on_t;
      wire [12:0] off_t;
      assign idx = (g == 0) ? {current_program, 1'b0} : {current_program, 1'b1};
      assign on_t = to_units(on_reg[idx]);
      assign off_t = to_units(off_reg[idx]);
      // on after the ON delay into the segment, off after a further OFF delay
      assign ts_next[g] = ts_assigned[g] && running &&
                          current_segment == tsseg_reg[idx] &&
                          ts_cnt_reg >= on_t && (ts_cnt_reg - on_t) < off_t;
    end
  endgenerate

  // ----------------------------------------------------------------
  // setpoint source
  // ----------------------------------------------------------------
  reg [15:0] fixed_reg;
  wire prot_open;
  assign prot_open = protect_level <= `PROT_OPEN_MAX;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      source_mode <= `SRC_PROG;
      fixed_reg <= `FIXED_DEF;
      mode_refused <= 1'b0;
      control_setpoint <= 16'h0000;
      fixed_lamp <= 1'b0;
      remote_lamp <= 1'b0;
      ts1_out <= 1'b0;
      ts2_out <= 1'b0;
    end else if (ce) begin
      mode_refused <= 1'b0;
      if (mode_wr) begin
        if (!prot_open || setpoint_source_select > `SRC_REMOTE ||
            (setpoint_source_select == `SRC_PROG && reset_op_fixed)) begin
          mode_refused <= 1'b1;
        end else begin
          source_mode <= setpoint_source_select;
        end
      end
      if (fixed_wr && prot_open) begin
        fixed_reg <= clamp_sp(stored_constant_setpoint, sp_lower_limit,
                              sp_upper_limit);
      end
      case (source_mode)
        `SRC_FIXED: control_setpoint <= fixed_reg;
        `SRC_REMOTE: control_setpoint <= remote_setpoint;
        default: control_setpoint <= prog_sp_reg;
      endcase
      fixed_lamp <= source_mode == `SRC_FIXED;
      remote_lamp <= source_mode == `SRC_REMOTE;
      ts1_out <= ts_next[0];
      ts2_out <= ts_next[1];
    end
  end
endmodule // setpoint_program_sequencer

/* File: sim/sequencer_monitor.sv */
// concurrent checks on the setpoint program sequencer ports
`timescale 1ns/10ps
module sequencer_monitor (
  // clock and reset
  input wire clk,
  input wire rst,
  // watched inputs
  input wire mode_wr,
  input wire [1:0] setpoint_source_select,
  input wire [2:0] protect_level,
  input wire reset_op_fixed,
  input wire [15:0] remote_setpoint,
  input wire [15:0] sp_lower_limit,
  input wire [15:0] sp_upper_limit,
  input wire run,
  // watched outputs
  input wire [15:0] control_setpoint,
  input wire fixed_lamp,
  input wire remote_lamp,
  input wire running,
  input wire finished,
  input wire [1:0] source_mode,
  input wire mode_refused
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // -----------------------------
  // setpoint source selection
  // -----------------------------
  prot_refuse_a: assert property (mode_wr && protect_level > 3'h1 |=> mode_refused)
    else $error("mode write at locked protection not refused");
  prot_hold_a: assert property (mode_wr && protect_level > 3'h1 |=> $stable(source_mode))
    else $error("source mode changed at locked protection");
  prog_refuse_a: assert property (mode_wr && reset_op_fixed
    && setpoint_source_select == 2'h0 |=> mode_refused && $stable(source_mode))
    else $error("program mode taken during fixed reset operation");
  mode_take_a: assert property (mode_wr && protect_level <= 3'h1
    && setpoint_source_select == 2'h2 |=> source_mode == 2'h2 && !mode_refused)
    else $error("remote mode write not taken");
  // lamps trail source_mode by one cycle
  fixed_lamp_a: assert property (fixed_lamp == $past(source_mode == 2'h1))
    else $error("fixed lamp does not follow mode");
  remote_lamp_a: assert property (remote_lamp == $past(source_mode == 2'h2))
    else $error("remote lamp does not follow mode");
  remote_value_a: assert property ((remote_lamp && $stable(remote_setpoint)) [*3]
    |-> control_setpoint == remote_setpoint)
    else $error("remote setpoint not used");
  fixed_range_a: assert property (fixed_lamp && $past(fixed_lamp, 2)
    |-> $signed(control_setpoint) >= $signed(sp_lower_limit)
    && $signed(control_setpoint) <= $signed(sp_upper_limit))
    else $error("fixed setpoint outside limits");
  // -----------------------------
  // program end
  // -----------------------------
  end_stop_a: assert property (finished && run |=> finished && !running)
    else $error("sequencer moved after end");

  refuse_c: cover property (mode_refused);
  remote_c: cover property (remote_lamp);
  fixed_c: cover property (fixed_lamp);
  end_c: cover property (finished);
endmodule // sequencer_monitor

/* File: sim/tb_setpoint_program_sequencer.sv */
// self-checking bench for the setpoint program sequencer
`timescale 1ns/10ps
module tb_setpoint_program_sequencer;
  reg clk = 0, rst = 1, ce = 1, run = 0, time_unit_ms = 0, cfg_wr = 0, seg_wr = 0;
  reg [2:0] start_program = 0, cfg_program = 0, protect_level = 0;
  reg [13:0] program_repeat_count = 0;
  reg [3:0] link_program = 4'h8;
  reg [5:0] segments_used = 6'h02;
  reg [4:0] ts1_segment = 5'h01, ts2_segment = 0;
  // one-unit off delay: a zero-time segment still shows its signal for one cycle
  reg [12:0] ts1_on_delay = 0, ts1_off_delay = 13'h0001, ts2_on_delay = 0;
  reg [12:0] ts2_off_delay = 13'h0001;
  reg [7:0] seg_addr = 0;
  reg [15:0] seg_setpoint = 0, stored_constant_setpoint = 0, remote_setpoint = 16'h0123;
  reg [12:0] seg_time = 0;
  // signal 2 stays unassigned, so its settings must stay inert
  reg ts1_assigned = 1, ts2_assigned = 0, mode_wr = 0, fixed_wr = 0, reset_op_fixed = 1;
  reg [1:0] setpoint_source_select = 0;
  reg [15:0] sp_lower_limit = 16'hff9c, sp_upper_limit = 16'h01f4;
  wire [15:0] control_setpoint;
  wire fixed_lamp, remote_lamp, ts1_out, ts2_out, running, finished, mode_refused;
  wire [2:0] current_program;
  wire [4:0] current_segment;
  wire [1:0] source_mode;
  integer mismatches = 0, num_checks = 0, cycles = 0, i;
  integer starts [0:7];
  reg run_q = 0, r;
  reg [1:0] ts_seen = 2'h0;

  setpoint_program_sequencer i_dut (.clk, .rst, .ce, .run, .start_program, .time_unit_ms,
    .cfg_wr, .cfg_program, .program_repeat_count, .link_program, .segments_used,
    .ts1_segment, .ts2_segment, .ts1_on_delay, .ts1_off_delay, .ts2_on_delay,
    .ts2_off_delay, .seg_wr, .seg_addr, .seg_setpoint, .seg_time, .ts1_assigned,
    .ts2_assigned, .mode_wr, .setpoint_source_select, .fixed_wr, .stored_constant_setpoint,
    .sp_lower_limit, .sp_upper_limit, .reset_op_fixed, .protect_level, .remote_setpoint,
    .control_setpoint, .fixed_lamp, .remote_lamp, .ts1_out, .ts2_out, .running, .finished,
    .current_program, .current_segment, .source_mode, .mode_refused);

  always #10 clk = ~clk;
  // count program starts and cut a hang short
  always @(posedge clk) begin
    run_q <= running;
    ts_seen <= ts_seen | {ts2_out, ts1_out};
    if (running && !run_q && current_segment === 5'h00) starts[current_program] += 1;
    cycles += 1;
    if (cycles == 5000) begin
      mismatches += 1;
      end_sim;
    end
  end

  task chk(input [15:0] g, input [15:0] e);
    num_checks += 1;
    if (g !== e) begin
      mismatches += 1;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task mode(input [1:0] c);
    @(posedge clk) mode_wr <= 1;
    setpoint_source_select <= c;
    @(posedge clk) mode_wr <= 0;
    r = 0;
    repeat (3) begin
      #1 r = r | mode_refused;
      @(posedge clk);
    end
  endtask
  task fixed(input [15:0] v);
    @(posedge clk) fixed_wr <= 1;
    stored_constant_setpoint <= v;
    @(posedge clk) fixed_wr <= 0;
    repeat (3) @(posedge clk);
  endtask
  task cfg(input [2:0] p, input [13:0] n, input [3:0] l);
    @(posedge clk) cfg_wr <= 1;
    cfg_program <= p;
    program_repeat_count <= n;
    link_program <= l;
    for (i = 0; i < 2; i += 1) begin
      @(posedge clk) cfg_wr <= 0;
      seg_wr <= 1;
      seg_addr <= {p, i[4:0]};
      seg_setpoint <= {12'h0, p, 1'b0} + i[15:0];
    end
    @(posedge clk) seg_wr <= 0;
  endtask
  task end_sim;
    $display("mismatches %0d, checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    for (i = 0; i < 8; i += 1) starts[i] = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk) #1;
    chk({14'h0, source_mode}, 16'h0000);
    mode(2'h0);
    chk({12'h0, source_mode, r, 1'b0}, 16'h0002);
    mode(2'h1);
    chk({13'h0, fixed_lamp, source_mode}, 16'h0005);
    chk(control_setpoint, 16'h0000);
    fixed(16'h0258);
    chk(control_setpoint, 16'h01f4);
    fixed(16'hff00);
    chk(control_setpoint, 16'hff9c);
    protect_level <= 3'h2;
    fixed(16'h0010);
    chk(control_setpoint, 16'hff9c);
    mode(2'h2);
    chk({12'h0, source_mode, r, 1'b0}, 16'h0006);
    protect_level <= 3'h1;
    mode(2'h3);
    chk({15'h0, r}, 16'h0001);
    mode(2'h2);
    chk({12'h0, fixed_lamp, remote_lamp, source_mode}, 16'h0006);
    chk(control_setpoint, remote_setpoint);
    reset_op_fixed <= 0;
    mode(2'h0);
    chk({12'h0, source_mode, r, remote_lamp}, 16'h0000);
    cfg(3'h0, 14'h0001, 4'h1);
    cfg(3'h1, 14'h0000, 4'h8);
    @(posedge clk) run <= 1;
    start_program <= 3'h0;
    for (i = 0; i < 500 && finished !== 1'b1; i += 1) @(posedge clk);
    chk(starts[0][15:0], 16'h0002);
    chk(starts[1][15:0], 16'h0001);
    repeat (20) @(posedge clk);
    #1 chk({14'h0, finished, running}, 16'h0002);
    chk({8'h0, current_program, current_segment}, 16'h0021);
    chk(control_setpoint, 16'h0003);
    chk({14'h0, ts_seen}, 16'h0001);
    end_sim;
  end
endmodule // tb_setpoint_program_sequencer

bind setpoint_program_sequencer sequencer_monitor i_mon (.clk, .rst, .mode_wr,
  .setpoint_source_select, .protect_level, .reset_op_fixed, .remote_setpoint,
  .sp_lower_limit, .sp_upper_limit, .run, .control_setpoint, .fixed_lamp, .remote_lamp,
  .running, .finished, .source_mode, .mode_refused);
